//--- bench/mrl_ctrl_model.sv
/* Controller model issuing mode-load commands.
 Assumes the bench calls load with all banks idle. */
`timescale 1ns/1ps
module mrl_ctrl_model (
	input wire clk_in,
	output logic [3:0] cmd_n_out = 4'hf,
	output logic cke_out = 1'b1,
	output logic [1:0] ba_out = 2'h0,
	output logic [13:0] addr_out = 14'h0000
);
	task load(input bit ext, input logic [13:0] a, input bit ck = 1);
		@(negedge clk_in);
		cmd_n_out = 4'h0;
		cke_out = ck;
		ba_out = {1'b0, ext};
		addr_out = a;
		@(negedge clk_in);
		cmd_n_out = 4'hf;
		cke_out = 1'b1;
		ba_out = ~ba_out;
		addr_out = ~a;
		repeat (2) @(negedge clk_in);
	endtask
endmodule // mrl_ctrl_model

//--- bench/mrl_properties.sv
/* Checker on the mode-load block ports.
 Bound into every mrl_mode_load instance. */
`timescale 1ns/1ps
module mrl_props #(parameter ADDR_W = 14) (
	input wire core_clk_in, srst_in, cke_in,
	input wire cs_n_in, ras_n_in, cas_n_in, we_n_in,
	input wire [1:0] ba_in, extended_ba_out, drive_strength_out, base_ba_out,
	input wire [ADDR_W-1:0] addr_in, base_mode_out, extended_mode_out,
	input wire [2:0] burst_len_code_out, read_latency_code_out,
	input wire burst_interleave_out, dll_reset_out, dll_enable_out,
	input wire load_busy_out, extended_loaded_out, base_loaded_out
);
	wire cmd = cke_in & ~(cs_n_in | ras_n_in | cas_n_in | we_n_in);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	a_base_capture: assert property (
		cmd && !ba_in[0] |-> ##3 base_mode_out == $past(addr_in, 3))
		else $error("base capture");
	a_ext_capture: assert property (
		cmd && ba_in[0] |-> ##3 extended_mode_out == $past(addr_in, 3))
		else $error("ext capture");
	a_ext_bank: assert property (
		cmd && ba_in[0] |-> ##3 extended_ba_out == $past(ba_in, 3))
		else $error("ext bank");
	a_base_bank: assert property (
		cmd && !ba_in[0] |-> ##3 base_ba_out == $past(ba_in, 3))
		else $error("base bank");
	a_base_written: assert property (
		cmd && !ba_in[0] |-> ##3 base_loaded_out)
		else $error("base written flag");
	a_dll_reset: assert property (
		cmd && !ba_in[0] && addr_in[8:7] == 2'h2
		|-> ##3 dll_reset_out ##1 !dll_reset_out)
		else $error("dll reset");
	a_dll_enable: assert property (
		dll_enable_out == (extended_loaded_out && !extended_mode_out[0]))
		else $error("dll enable");
	a_drive_code: assert property (
		drive_strength_out == {extended_mode_out[6], extended_mode_out[1]})
		else $error("drive code");
	a_burst_fields: assert property (
		{read_latency_code_out, burst_interleave_out, burst_len_code_out}
		== base_mode_out[6:0]) else $error("burst fields");
	a_busy_two: assert property (
		cmd |-> ##3 load_busy_out [*2] ##1 !load_busy_out)
		else $error("busy length");
endmodule // mrl_props
bind mrl_mode_load mrl_props #(.ADDR_W(ADDR_W)) chk_u (
	.core_clk_in(core_clk_in), .srst_in(srst_in), .cke_in(cke_in),
	.cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in),
	.we_n_in(we_n_in), .ba_in(ba_in), .extended_ba_out(extended_ba_out),
	.drive_strength_out(drive_strength_out), .base_ba_out(base_ba_out),
	.addr_in(addr_in), .base_mode_out(base_mode_out),
	.extended_mode_out(extended_mode_out),
	.burst_len_code_out(burst_len_code_out),
	.read_latency_code_out(read_latency_code_out),
	.burst_interleave_out(burst_interleave_out),
	.dll_reset_out(dll_reset_out), .dll_enable_out(dll_enable_out),
	.load_busy_out(load_busy_out),
	.extended_loaded_out(extended_loaded_out),
	.base_loaded_out(base_loaded_out)
);

//--- bench/testbench.sv
/* Self-checking bench for mrl_mode_load.
 Assumes the controller model drives all command, CKE, bank and address pins. */
`timescale 1ns/1ps
module testbench;
	logic clk = 0, srst = 1;
	int bad_count = 0, comparisons = 0, cyc = 0, i;
	logic [13:0] tb [8] = '{14'h0021, 14'h0039, 14'h0032, 14'h0023,
		14'h0061, 14'h006A, 14'h00A2, 14'h0122};
	wire [3:0] cn;
	wire [1:0] ba, ds;
	wire [13:0] addr, bm, em;
	wire cke, br, dr, tm, de, dsr;
	initial forever #4 clk = ~clk;
	mrl_ctrl_model m (.clk_in(clk), .cmd_n_out(cn), .cke_out(cke),
		.ba_out(ba), .addr_out(addr));
	mrl_mode_load dut_u (.core_clk_in(clk), .srst_in(srst),
		.cs_n_in(cn[3]), .ras_n_in(cn[2]), .cas_n_in(cn[1]),
		.we_n_in(cn[0]), .cke_in(cke), .ba_in(ba), .addr_in(addr),
		.base_mode_out(bm), .base_ba_out(), .extended_mode_out(em),
		.extended_ba_out(), .burst_len_code_out(),
		.burst_interleave_out(), .read_latency_code_out(),
		.base_reserved_out(br), .dll_reset_out(dr), .test_mode_out(tm),
		.dll_enable_out(de), .drive_strength_out(ds),
		.drive_reserved_out(dsr), .load_busy_out(),
		.base_loaded_out(), .extended_loaded_out());
	task chk(input logic [13:0] s, e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task go(input bit ext, input logic [13:0] a);
		m.load(ext, a);
		@(negedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 500) begin
			bad_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		srst = 0;
		for (i = 0; i < 4; i++) begin
			go(1, {7'h0, i[1], 4'h0, i[0], i[0]});
			chk(em, {7'h0, i[1], 4'h0, i[0], i[0]});
			chk(de, !i[0]);
			chk(ds, i[1:0]);
			chk(dsr, i == 2);
		end
		for (i = 0; i < 8; i++) begin
			m.load(0, tb[i]);
			chk(dr, tb[i][8:7] == 2);
			@(negedge clk);
			chk(bm, tb[i]);
			chk(br, 0);
			chk(tm, tb[i][7]);
			chk(em, 14'h0043);
		end
		@(negedge clk);
		chk(dr, 0);
		go(0, 14'h0010);
		chk(br, 1);
		m.load(0, 14'h0022, 0);
		@(negedge clk);
		chk(bm, 14'h0010);
		give_verdict;
	end
endmodule // testbench

//--- src/mrl_cmd_decode.v
/*
 Command decoder: recognises a mode-load command on the registered
 control pins and classifies it by bank-address bit 0.
 Assumes inputs already synchronised to core_clk_in.
*/
`timescale 1ns/1ps
`include "mrl_regs.vh"

module mrl_cmd_decode (
	// Control pins, active low except cke_in (active high)
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	input wire cke_in,
	// Bank address
	input wire [`MRL_BA_W-1:0] ba_in,
	// Decoded strobes
	output wire base_mode_load_out,
	output wire extended_mode_load_out
);
	wire load_cmd;

	assign load_cmd = cke_in & ~cs_n_in & ~ras_n_in & ~cas_n_in & ~we_n_in;
	// Bit 1 is reserved and ignored
	assign base_mode_load_out = load_cmd & ~ba_in[`MRL_BA_SEL_BIT];
	assign extended_mode_load_out = load_cmd & ba_in[`MRL_BA_SEL_BIT];
endmodule // mrl_cmd_decode

//--- src/mrl_mode_load.v
/*
 Mode-register load logic: captures address and bank pins into the
 basic or extended mode register on a load command and decodes the
 stored fields into operating controls.
 Assumes a controller drives the pins from another domain, so every
 pin is passed through two flip-flops before use.
*/
// Behaviour
// - A8..A7 test field; 10 requests DLL reset
// - BA0 low basic, high extended target
// - All-low command with CKE and BA0 high: extended load
// - Latch A0..A13 and BA on command edge
// - Reloads accepted any time, busy or idle
// - Extended A0: 0 DLL on, 1 off
// - Drive strength from A6 high, A1 low
// - Burst length A2..A0, burst type A3
// - Read latency codes from A6..A4
`timescale 1ns/1ps
`include "mrl_regs.vh"

module mrl_mode_load #(
	parameter ADDR_W = `MRL_ADDR_W
) (
	// Clock and reset
	input wire core_clk_in,
	input wire srst_in,
	// Command pins
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	input wire cke_in,
	// Address pins
	input wire [`MRL_BA_W-1:0] ba_in,
	input wire [ADDR_W-1:0] addr_in,
	// Stored registers
	output reg [ADDR_W-1:0] base_mode_out,
	output reg [`MRL_BA_W-1:0] base_ba_out,
	output reg [ADDR_W-1:0] extended_mode_out,
	output reg [`MRL_BA_W-1:0] extended_ba_out,
	// Decoded controls
	output reg [2:0] burst_len_code_out,
	output reg burst_interleave_out,
	output reg [2:0] read_latency_code_out,
	output reg base_reserved_out,
	output reg dll_reset_out,
	output reg test_mode_out,
	output reg dll_enable_out,
	output reg [1:0] drive_strength_out,
	output reg drive_reserved_out,
	output reg load_busy_out,
	output reg base_loaded_out,
	output reg extended_loaded_out
);
	reg [4:0] ctl_s1_reg;
	reg [4:0] ctl_s2_reg;
	reg [`MRL_BA_W-1:0] ba_s1_reg;
	reg [`MRL_BA_W-1:0] ba_s2_reg;
	reg [ADDR_W-1:0] addr_s1_reg;
	reg [ADDR_W-1:0] addr_s2_reg;
	reg [1:0] busy_cnt_reg;
	wire base_mode_load;
	wire extended_mode_load;
	wire [ADDR_W-1:0] bm_next;
	wire [ADDR_W-1:0] em_next;
	wire [1:0] ds_next;
	wire [1:0] tm_next;
	wire [2:0] burst_len_next;
	wire burst_interleave_next;
	wire [2:0] read_latency_next;
	wire base_reserved_next;
	wire dll_reset_next;
	wire test_mode_next;
	wire dll_enable_next;
	wire drive_reserved_next;
	wire base_written;
	wire extended_written;

	// Busy cycles left after the load cycle itself
	localparam integer BUSY_LOAD = `MRL_TMRD_CYCLES - 1;

	// Legal burst length and read latency codes
	function bl_valid;
		input [2:0] c;
		bl_valid = (c == `MRL_BL_2) || (c == `MRL_BL_4) || (c == `MRL_BL_8);
	endfunction

	function cl_valid;
		input [2:0] c;
		cl_valid = (c == `MRL_CL_2) || (c == `MRL_CL_3) || (c == `MRL_CL_2P5);
	endfunction

	// Two-stage pin synchronisers
	// Pins are synchronised one by one, so the controller must hold
	// command and address steady for the whole load cycle
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			ctl_s1_reg <= 5'h0f;
			ctl_s2_reg <= 5'h0f;
			ba_s1_reg <= 2'h0;
			ba_s2_reg <= 2'h0;
			addr_s1_reg <= `MRL_ADDR_RESET;
			addr_s2_reg <= `MRL_ADDR_RESET;
		end else begin
			ctl_s1_reg <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in};
			ctl_s2_reg <= ctl_s1_reg;
			ba_s1_reg <= ba_in;
			ba_s2_reg <= ba_s1_reg;
			addr_s1_reg <= addr_in;
			addr_s2_reg <= addr_s1_reg;
		end
	end

	// Command decode on the synchronised pins
	mrl_cmd_decode u_dec (
		.cs_n_in(ctl_s2_reg[3]),
		.ras_n_in(ctl_s2_reg[2]),
		.cas_n_in(ctl_s2_reg[1]),
		.we_n_in(ctl_s2_reg[0]),
		.cke_in(ctl_s2_reg[4]),
		.ba_in(ba_s2_reg),
		.base_mode_load_out(base_mode_load),
		.extended_mode_load_out(extended_mode_load)
	);

	assign bm_next = base_mode_load ? addr_s2_reg : base_mode_out;
	assign em_next = extended_mode_load ? addr_s2_reg : extended_mode_out;
	assign ds_next = {em_next[`MRL_DS_HIGH_BIT], em_next[`MRL_DS_LOW_BIT]};
	assign tm_next = bm_next[`MRL_TM_LSB +: `MRL_TM_W];

	// Base reserved, test-mode and DLL-enable flags only count once their register has been written
	assign base_written = base_loaded_out | base_mode_load;
	assign extended_written = extended_loaded_out | extended_mode_load;

	assign burst_len_next = bm_next[`MRL_BL_LSB +: `MRL_BL_W];
	assign burst_interleave_next = bm_next[`MRL_BT_BIT];
	assign read_latency_next = bm_next[`MRL_CL_LSB +: `MRL_CL_W];
	// Reserved codes are stored as given and only flagged
	assign base_reserved_next = base_written &
		~(bl_valid(burst_len_next) & cl_valid(read_latency_next));
	// One-cycle DLL reset request per load
	assign dll_reset_next = base_mode_load &
		(tm_next == `MRL_TM_DLL_RESET);
	assign test_mode_next = base_written &
		(tm_next != `MRL_TM_NORMAL) &
		(tm_next != `MRL_TM_DLL_RESET);
	assign dll_enable_next = extended_written &
		~em_next[`MRL_DLL_DIS_BIT];
	assign drive_reserved_next = (ds_next == `MRL_DS_RFU);

	// Stored registers and their written flags
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			base_mode_out <= `MRL_ADDR_RESET;
			base_ba_out <= 2'h0;
			extended_mode_out <= `MRL_ADDR_RESET;
			extended_ba_out <= 2'h0;
			base_loaded_out <= 1'b0;
			extended_loaded_out <= 1'b0;
		end else begin
			// Reload allowed at any time; idle banks are caller's duty
			if (base_mode_load) begin
				base_mode_out <= addr_s2_reg;
				base_ba_out <= ba_s2_reg;
				base_loaded_out <= 1'b1;
			end
			if (extended_mode_load) begin
				extended_mode_out <= addr_s2_reg;
				extended_ba_out <= ba_s2_reg;
				extended_loaded_out <= 1'b1;
			end
		end
	end

	// Decoded fields follow the value being stored
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			burst_len_code_out <= 3'h0;
			burst_interleave_out <= 1'b0;
			read_latency_code_out <= 3'h0;
			base_reserved_out <= 1'b0;
			dll_reset_out <= 1'b0;
			test_mode_out <= 1'b0;
			dll_enable_out <= 1'b0;
			drive_strength_out <= `MRL_DS_FULL;
			drive_reserved_out <= 1'b0;
		end else begin
			burst_len_code_out <= burst_len_next;
			burst_interleave_out <= burst_interleave_next;
			read_latency_code_out <= read_latency_next;
			base_reserved_out <= base_reserved_next;
			dll_reset_out <= dll_reset_next;
			test_mode_out <= test_mode_next;
			dll_enable_out <= dll_enable_next;
			drive_strength_out <= ds_next;
			drive_reserved_out <= drive_reserved_next;
		end
	end

	// Busy for the load-to-command window
	// Restarts on every load, so back-to-back loads stretch it
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			busy_cnt_reg <= 2'h0;
			load_busy_out <= 1'b0;
		end else if (base_mode_load | extended_mode_load) begin
			busy_cnt_reg <= BUSY_LOAD[1:0];
			load_busy_out <= 1'b1;
		end else if (busy_cnt_reg != 2'h0) begin
			busy_cnt_reg <= busy_cnt_reg - 2'h1;
			load_busy_out <= 1'b1;
		end else begin
			load_busy_out <= 1'b0;
		end
	end
endmodule // mrl_mode_load

//--- src/mrl_regs.vh
/*
 Constants for the mode-register load block: field code values,
 field positions and widths, and timing counts.
 Assumes inclusion by bare name from design files.
*/
`ifndef MRL_REGS_VH
`define MRL_REGS_VH

`define MRL_ADDR_W 14
`define MRL_BA_W 2
`define MRL_BA_SEL_BIT 0
`define MRL_BA_RFU_BIT 1
`define MRL_BL_LSB 0
`define MRL_BL_W 3
`define MRL_BT_BIT 3
`define MRL_CL_LSB 4
`define MRL_CL_W 3
`define MRL_TM_LSB 7
`define MRL_TM_W 2
`define MRL_TM_NORMAL 2'h0
`define MRL_TM_DLL_RESET 2'h2
`define MRL_BL_2 3'h1
`define MRL_BL_4 3'h2
`define MRL_BL_8 3'h3
`define MRL_CL_2 3'h2
`define MRL_CL_3 3'h3
`define MRL_CL_2P5 3'h6
`define MRL_DLL_DIS_BIT 0
`define MRL_DS_LOW_BIT 1
`define MRL_DS_HIGH_BIT 6
`define MRL_DS_FULL 2'h0
`define MRL_DS_WEAK 2'h1
`define MRL_DS_RFU 2'h2
`define MRL_DS_MATCHED 2'h3
`define MRL_ADDR_RESET 14'h0000
`define MRL_TMRD_CYCLES 2

`endif
